// >>> hdl/pefp_fault_policy.sv
// One fault channel: registered interrupt pulse and protective action
module pefp_fault_policy (
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic enable,
   input  wire logic auto_protect,
   input  wire logic condition,
   output logic      irq,
   output logic      shutdown,
   output logic      limit
);
   typedef struct packed {
      logic prev;
      logic irq;
      logic shutdown;
      logic limit;
   } pefp_chan_t;
   pefp_chan_t state;
   pefp_chan_t next_state;

   always_comb begin
      next_state = state;
      // Gate the condition first so a disabled channel never arms the edge detector
      next_state.prev     = condition & enable;
      next_state.irq      = condition & enable & ~state.prev;
      next_state.shutdown = condition & enable & auto_protect;
      next_state.limit    = condition & enable & ~auto_protect;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign irq      = state.irq;
   assign shutdown = state.shutdown;
   assign limit    = state.limit;
endmodule

// >>> hdl/pefp_power_control.sv
// Power stage control and fault protection register bank
`include "pefp_cfg.svh"
// Contract
// - Step-down mode bit 0 selects auto PFM/PWM, 1 selects forced PWM.
// - Over-voltage enable set: interrupt on over-voltage and, with auto bit clear, limit boost output.
// - Over-voltage auto-protect bit: 0 forbids, 1 permits automatic protection.
// - Over-voltage enable clear: no interrupt and no protection regardless of auto bit.
// - Enable set, auto clear: interrupt and pulse skipping while over-voltage persists.
// - Enable and auto set: interrupt and automatic power-down sequence start.
// - Over-current enable alone gives an interrupt and nothing else.
// - Over-temperature: off, interrupt, or interrupt plus power-down by enable and auto.
// - Over-current: off, interrupt, or interrupt plus power-down by enable and auto.
module pefp_power_control (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       step_up_overvoltage,
   input  wire logic       amplifier_overtemp,
   input  wire logic       amplifier_overcurrent,
   input  wire logic       step_up_power_good,
   output logic      [7:0] reg_rdata,
   output logic            step_down_enable,
   output logic            step_down_mode_select,
   output logic            linear_regulator_enable,
   output logic            gate_supply_current_mode,
   output logic            step_up_enable,
   output logic            amplifier_master_enable,
   output logic            step_up_pulse_skip,
   output logic            auto_power_down_start,
   output logic            step_up_overvoltage_irq,
   output logic            amplifier_overtemp_irq,
   output logic            amplifier_overcurrent_irq
);
   pefp_pkg::pefp_regs_t  regs;
   pefp_pkg::pefp_regs_t  next_regs;
   pefp_pkg::pefp_fault_t ov_out;
   pefp_pkg::pefp_fault_t ot_out;
   pefp_pkg::pefp_fault_t oc_out;
   logic                  ot_limit;
   logic                  oc_limit;

   typedef struct packed {
      logic buck_en;
      logic buck_mode;
      logic ldo_en;
      logic gate_mode;
      logic boost_en;
      logic amp_en;
      logic down_start;
   } pefp_out_t;
   pefp_out_t outs;
   pefp_out_t next_outs;
   logic [7:0] stage_view;
   logic [7:0] fault_view;

   always_comb begin
      next_regs = regs;
      if (reg_write && reg_addr == `PEFP_ADDR_STAGE) begin
         next_regs.power_stage_control = reg_wdata & `PEFP_STAGE_MASK;
      end
      if (reg_write && reg_addr == `PEFP_ADDR_FAULT) begin
         next_regs.fault_protection_control = reg_wdata & `PEFP_FAULT_MASK;
      end
      // Unmapped reads return zero; reserved bits are masked on write
      if (reg_read && reg_addr == `PEFP_ADDR_STAGE) begin
         next_regs.rdata = regs.power_stage_control;
      end else if (reg_read && reg_addr == `PEFP_ADDR_FAULT) begin
         next_regs.rdata = regs.fault_protection_control;
      end else if (reg_read) begin
         next_regs.rdata = `PEFP_ZERO_BYTE;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         regs.power_stage_control      <= `PEFP_RST_STAGE;
         regs.fault_protection_control <= `PEFP_RST_FAULT;
         regs.rdata                    <= `PEFP_ZERO_BYTE;
      end else begin
         regs <= next_regs;
      end
   end

   // Decode from the register itself so each bit reaches the registered outputs one cycle after the register updates
   assign stage_view = regs.power_stage_control;
   assign fault_view = regs.fault_protection_control;

   pefp_fault_policy u_ov (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .enable       (fault_view[`PEFP_BIT_OV_EN]),
      .auto_protect (fault_view[`PEFP_BIT_OV_AP]),
      .condition    (step_up_overvoltage),
      .irq          (ov_out.irq),
      .shutdown     (ov_out.action),
      .limit        (step_up_pulse_skip)
   );

   pefp_fault_policy u_ot (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .enable       (fault_view[`PEFP_BIT_OT_EN]),
      .auto_protect (fault_view[`PEFP_BIT_OT_AP]),
      .condition    (amplifier_overtemp),
      .irq          (ot_out.irq),
      .shutdown     (ot_out.action),
      .limit        (ot_limit)
   );

   pefp_fault_policy u_oc (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .enable       (fault_view[`PEFP_BIT_OC_EN]),
      .auto_protect (fault_view[`PEFP_BIT_OC_AP]),
      .condition    (amplifier_overcurrent),
      .irq          (oc_out.irq),
      .shutdown     (oc_out.action),
      .limit        (oc_limit)
   );

   always_comb begin
      next_outs            = outs;
      next_outs.buck_en    = stage_view[`PEFP_BIT_BUCK_EN];
      next_outs.buck_mode  = stage_view[`PEFP_BIT_BUCK_MODE];
      next_outs.ldo_en     = stage_view[`PEFP_BIT_LDO_EN];
      next_outs.gate_mode  = stage_view[`PEFP_BIT_GATE_MODE];
      next_outs.boost_en   = stage_view[`PEFP_BIT_BOOST_EN];
      next_outs.amp_en     = stage_view[`PEFP_BIT_AMP_EN] &
                             (~stage_view[`PEFP_BIT_AMP_PG] | step_up_power_good);
      // Gated from the pins so the registered start lines up with the channel flops
      next_outs.down_start = (step_up_overvoltage & fault_view[`PEFP_BIT_OV_EN] &
                              fault_view[`PEFP_BIT_OV_AP]) |
                             (amplifier_overtemp & fault_view[`PEFP_BIT_OT_EN] &
                              fault_view[`PEFP_BIT_OT_AP]) |
                             (amplifier_overcurrent & fault_view[`PEFP_BIT_OC_EN] &
                              fault_view[`PEFP_BIT_OC_AP]);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         outs <= '0;
      end else begin
         outs <= next_outs;
      end
   end

   assign reg_rdata                 = regs.rdata;
   assign step_down_enable          = outs.buck_en;
   assign step_down_mode_select     = outs.buck_mode;
   assign linear_regulator_enable   = outs.ldo_en;
   assign gate_supply_current_mode  = outs.gate_mode;
   assign step_up_enable            = outs.boost_en;
   assign amplifier_master_enable   = outs.amp_en;
   // Over-current auto path only when its own auto bit is set; enable alone is irq only
   assign auto_power_down_start     = outs.down_start;
   assign step_up_overvoltage_irq   = ov_out.irq;
   assign amplifier_overtemp_irq    = ot_out.irq;
   assign amplifier_overcurrent_irq = oc_out.irq;
endmodule

// >>> shared/pefp_cfg.svh
// Register offsets, field positions and reset values of the power control bank
`ifndef PEFP_CFG_SVH
`define PEFP_CFG_SVH
`define PEFP_ADDR_STAGE      8'h18
`define PEFP_ADDR_FAULT      8'h19
`define PEFP_RST_STAGE       8'h05
`define PEFP_RST_FAULT       8'h01
`define PEFP_BIT_BUCK_EN     0
`define PEFP_BIT_BUCK_MODE   1
`define PEFP_BIT_LDO_EN      2
`define PEFP_BIT_GATE_MODE   3
`define PEFP_BIT_BOOST_EN    4
`define PEFP_BIT_AMP_EN      5
`define PEFP_BIT_AMP_PG      6
`define PEFP_BIT_OV_EN       0
`define PEFP_BIT_OV_AP       1
`define PEFP_BIT_OT_EN       2
`define PEFP_BIT_OT_AP       3
`define PEFP_BIT_OC_EN       4
`define PEFP_BIT_OC_AP       5
`define PEFP_STAGE_MASK      8'h7f
`define PEFP_FAULT_MASK      8'h3f
`define PEFP_ZERO_BYTE       8'h00
`endif

// >>> shared/pefp_pkg.sv
// Types of the power enable and fault protection bank
package pefp_pkg;
   typedef struct packed {
      logic [7:0] power_stage_control;
      logic [7:0] fault_protection_control;
      logic [7:0] rdata;
   } pefp_regs_t;
   typedef struct packed {
      logic irq;
      logic action;
   } pefp_fault_t;
endpackage

// >>> verif/pefp_host_model.sv
// Control processor model issuing register strobes
module pefp_host_model (
   input  wire logic core_clk,
   output logic      reg_write,
   output logic      reg_read,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_write, reg_read, reg_addr, reg_wdata} = 18'h0_0000;
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {reg_write, reg_read, reg_addr, reg_wdata} = {wr, !wr, a, d};
      @(negedge core_clk);
      // Idle bus shows inverted data so stale values never look valid
      {reg_write, reg_read, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
   endtask
endmodule

// >>> verif/pefp_power_control_asserts.sv
// Checker of the power stage and fault protection bank
`include "pefp_cfg.svh"
module pefp_power_control_asserts (
   input wire logic       core_clk, reset_n, reg_write, reg_read,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   input wire logic       step_up_overvoltage, amplifier_overtemp, amplifier_overcurrent,
   input wire logic       step_up_power_good, step_down_enable, step_down_mode_select,
   input wire logic       linear_regulator_enable, gate_supply_current_mode, step_up_enable,
   input wire logic       amplifier_master_enable, step_up_pulse_skip, auto_power_down_start,
   input wire logic       step_up_overvoltage_irq, amplifier_overtemp_irq,
   input wire logic       amplifier_overcurrent_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] stage, fault, stage_q, fault_q;
      logic [2:0] cond_q, armed_q, armed_qq;
      logic       good_q;
   } pefp_chk_t;
   pefp_chk_t  st, next_st;
   logic [7:0] rd_exp;
   always_comb begin
      next_st = st;
      if (reg_write && reg_addr == `PEFP_ADDR_STAGE) next_st.stage = reg_wdata & `PEFP_STAGE_MASK;
      if (reg_write && reg_addr == `PEFP_ADDR_FAULT) next_st.fault = reg_wdata & `PEFP_FAULT_MASK;
      next_st.stage_q = st.stage;
      next_st.fault_q = st.fault;
      next_st.cond_q = {amplifier_overcurrent, amplifier_overtemp, step_up_overvoltage};
      // Interrupt follows the rise of the enabled condition, not of the raw one
      next_st.armed_q = next_st.cond_q & {st.fault[4], st.fault[2], st.fault[0]};
      next_st.armed_qq = st.armed_q;
      next_st.good_q = step_up_power_good;
   end
   always_comb rd_exp = (reg_addr == `PEFP_ADDR_STAGE) ? st.stage :
                        (reg_addr == `PEFP_ADDR_FAULT) ? st.fault : `PEFP_ZERO_BYTE;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) st <= {`PEFP_RST_STAGE, `PEFP_RST_FAULT, 26'h000_0000};
      else st <= next_st;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   stage_outputs_a: assert property ({step_up_enable, gate_supply_current_mode,
      linear_regulator_enable, step_down_mode_select, step_down_enable} == st.stage_q[4:0])
      else $error("stage outputs differ from register");
   amp_gating_a: assert property (amplifier_master_enable ==
      (st.stage_q[5] && (!st.stage_q[6] || st.good_q))) else $error("amplifier enable wrong");
   ov_skip_a: assert property (step_up_pulse_skip ==
      (st.fault_q[0] && !st.fault_q[1] && st.cond_q[0])) else $error("pulse skip wrong");
   power_down_a: assert property (auto_power_down_start == (
      &{st.fault_q[1:0], st.cond_q[0]} | &{st.fault_q[3:2], st.cond_q[1]} |
      &{st.fault_q[5:4], st.cond_q[2]})) else $error("power-down start wrong");
   ov_irq_a: assert property (step_up_overvoltage_irq ==
      (st.armed_q[0] && !st.armed_qq[0])) else $error("over-voltage irq wrong");
   ot_irq_a: assert property (amplifier_overtemp_irq ==
      (st.armed_q[1] && !st.armed_qq[1])) else $error("over-temperature irq wrong");
   oc_irq_a: assert property (amplifier_overcurrent_irq ==
      (st.armed_q[2] && !st.armed_qq[2])) else $error("over-current irq wrong");
   irq_pulse_a: assert property ($rose(step_up_overvoltage_irq) |=>
      !step_up_overvoltage_irq) else $error("irq longer than one cycle");
   read_data_a: assert property (reg_read |=> reg_rdata == $past(rd_exp))
      else $error("read data wrong");
endmodule
bind pefp_power_control pefp_power_control_asserts u_pefp_power_control_asserts (.*);

// >>> verif/tb_top.sv
// Bench for the power stage and fault protection bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk = 0, reset_n = 0, ov = 0, ot = 0, oc = 0, pg = 0, rd_d = 0;
   logic       reg_write, reg_read;
   logic [7:0] reg_addr, reg_wdata, rdata, v;
   logic [2:0] irqv;
   logic [4:0] stg;
   logic       skip, pds;
   logic [7:0] rd_q[$], irq_q[$];
   int         err_total = 0, total_checks = 0, cycles = 0, seed = 82;
   always #25 core_clk = ~core_clk;
   pefp_host_model u_pefp_host_model (.core_clk(core_clk), .reg_write(reg_write),
      .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   pefp_power_control u_pefp_power_control (.core_clk(core_clk), .reset_n(reset_n),
      .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .step_up_overvoltage(ov), .amplifier_overtemp(ot), .amplifier_overcurrent(oc),
      .step_up_power_good(pg), .reg_rdata(rdata), .step_down_enable(stg[0]),
      .step_down_mode_select(stg[1]), .linear_regulator_enable(stg[2]),
      .gate_supply_current_mode(stg[3]), .step_up_enable(stg[4]),
      .amplifier_master_enable(), .step_up_pulse_skip(skip),
      .auto_power_down_start(pds), .step_up_overvoltage_irq(irqv[0]),
      .amplifier_overtemp_irq(irqv[1]), .amplifier_overcurrent_irq(irqv[2]));
   task automatic final_report();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_pefp_host_model.access(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      u_pefp_host_model.access(1'b0, a, 8'h00);
   endtask
   always @(posedge core_clk) rd_d <= reg_read;
   always @(negedge core_clk) begin
      cycles++;
      pg = 1'($random(seed));
      if (cycles == 2000) begin
         err_total++;
         final_report();
      end
      if (rd_d) cmp(rd_q.pop_front(), rdata);
      if (|irqv) cmp(irq_q.size() ? irq_q.pop_front() : 8'h00, {5'h00, irqv});
   end
   initial begin
      repeat (6) @(negedge core_clk);
      reset_n = 1;
      rd(8'h18, 8'h05);
      rd(8'h19, 8'h01);
      rd(8'h1a, 8'h00);
      wr(8'h18, 8'hff);
      rd(8'h18, 8'h7f);
      wr(8'h19, 8'hff);
      rd(8'h19, 8'h3f);
      wr(8'h1a, 8'h55);
      rd(8'h1a, 8'h00);
      for (int i = 0; i < 6; i++) begin
         v = 8'($random(seed));
         wr(8'h18, v);
         rd(8'h18, v & 8'h7f);
         cmp({3'h0, stg}, v & 8'h1f);
      end
      // Each channel in turn through every enable and auto-protect pairing
      for (int m = 0; m < 12; m++) begin
         wr(8'h19, 8'((m % 4) << (2 * (m / 4))));
         if ((m % 4) & 1) irq_q.push_back(8'(1 << (m / 4)));
         @(negedge core_clk);
         {oc, ot, ov} = 3'(1 << (m / 4));
         @(negedge core_clk);
         cmp({6'h00, skip, pds}, {6'h00, m == 1, (m % 4) == 3});
         repeat (2) @(negedge core_clk);
         {oc, ot, ov} = 3'h0;
         @(negedge core_clk);
      end
      cmp(8'(irq_q.size()), 8'h00);
      final_report();
   end
endmodule
